// ===== src/cursor2_geom_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cursor2_geom_regs.svh"
// What this block does
// - With vertical extension on, the height is (extension field + 1) * 4 lines.
// - Base-low bits 7-4 give base offset bits 15-12 of the 22-bit offset.
// - Base-high bits 5-0 give base offset bits 21-16.
// - All patterns lie inside one 4KB space starting at the base offset.
// - Base-low bits 3-0 select one of up to 16 patterns, count set by mode.
// - Base-high bits 7-6 always read as zero.
// - X position is sign-magnitude: low byte, high bits 2-0, sign in bit 7.
// - Y position is sign-magnitude: low byte, high bits 2-0, sign in bit 7.
// - Bits 6-3 of the X-high and Y-high registers do not move the cursor.
// - Control bit 3 enables vertical extension, reset 0, else mode height.
// - Control bit 4 picks the origin: 0 border corner, 1 active area corner.
module cursor2_geom_regs
(
    input  wire logic                        sys_clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [7:0]                  index_i,
    input  wire logic                        data_wr_i,
    input  wire logic                        data_rd_i,
    input  wire logic [7:0]                  data_wdata_i,
    input  wire logic                        frame_start_i,
    output logic      [7:0]                  data_rdata_o,
    output logic                             data_hit_o,
    output cursor2_geom_pkg::geometry_t      geometry_o,
    output logic      [2:0]                  mode_o
);
    typedef struct packed {
        cursor2_geom_pkg::reg_file_t regs;
        cursor2_geom_pkg::geometry_t geom;
        logic [2:0]                  mode;
        logic [7:0]                  rdata;
        logic                        hit;
    } state_t;

    state_t      st;
    state_t      next_st;
    logic [21:0] live_base;
    logic [21:0] live_addr;

    assign live_base = {st.regs.base_high[5:0],
                        st.regs.base_low[7:`BASE_LOW_ADDR_LSB],
                        12'h000};

    cursor2_pattern_addr u_addr
    (
        .base_i  (live_base),
        .index_i (st.regs.base_low[3:0]),
        .mode_i  (st.regs.control[2:0]),
        .addr_o  (live_addr)
    );

    always_comb
    begin
        next_st = st;
        next_st.hit = 1'b0;
        if (data_wr_i)
        begin
            case (index_i)
                `IDX_CONTROL:    next_st.regs.control    = data_wdata_i;
                `IDX_HEIGHT_EXT: next_st.regs.height_ext = data_wdata_i;
                `IDX_BASE_LOW:   next_st.regs.base_low   = data_wdata_i;
                `IDX_BASE_HIGH:  next_st.regs.base_high  =
                                     data_wdata_i & `BASE_HIGH_MASK;
                `IDX_X_LOW:      next_st.regs.x_low      = data_wdata_i;
                `IDX_X_HIGH:     next_st.regs.x_high     = data_wdata_i;
                `IDX_Y_LOW:      next_st.regs.y_low      = data_wdata_i;
                `IDX_Y_HIGH:     next_st.regs.y_high     = data_wdata_i;
                default:         next_st.regs            = st.regs;
            endcase
        end
        if (data_rd_i)
        begin
            next_st.hit = 1'b1;
            // Read data shows stored values, not the frame-latched copy.
            case (index_i)
                `IDX_CONTROL:    next_st.rdata = st.regs.control;
                `IDX_HEIGHT_EXT: next_st.rdata = st.regs.height_ext;
                `IDX_BASE_LOW:   next_st.rdata = st.regs.base_low;
                `IDX_BASE_HIGH:  next_st.rdata = st.regs.base_high
                                     & `BASE_HIGH_MASK;
                `IDX_X_LOW:      next_st.rdata = st.regs.x_low;
                `IDX_X_HIGH:     next_st.rdata = st.regs.x_high;
                `IDX_Y_LOW:      next_st.rdata = st.regs.y_low;
                `IDX_Y_HIGH:     next_st.rdata = st.regs.y_high;
                default:
                begin
                    next_st.rdata = `RST_BYTE;
                    next_st.hit   = 1'b0;
                end
            endcase
        end
        // Geometry is copied only at frame start so a half-written position
        // never tears the cursor mid-frame.
        if (frame_start_i)
        begin
            next_st.mode = st.regs.control[2:0];
            next_st.geom.origin_active =
                st.regs.control[`CTL_ORIGIN_BIT];
            next_st.geom.height_override =
                st.regs.control[`CTL_VEXT_BIT];
            // Eleven bits: an extension of FF asks for 1024 lines.
            next_st.geom.height_lines =
                ({3'b000, st.regs.height_ext} + 11'h001)
                << `HEIGHT_LINE_SHIFT;
            next_st.geom.base_offset   = live_base;
            next_st.geom.pattern_index = st.regs.base_low[3:0];
            next_st.geom.pattern_addr  = live_addr;
            next_st.geom.x_sign = st.regs.x_high[`POS_SIGN_BIT];
            next_st.geom.x_mag  = {st.regs.x_high[2:0],
                                   st.regs.x_low};
            next_st.geom.y_sign = st.regs.y_high[`POS_SIGN_BIT];
            next_st.geom.y_mag  = {st.regs.y_high[2:0],
                                   st.regs.y_low};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign data_rdata_o = st.rdata;
    assign data_hit_o   = st.hit;
    assign geometry_o   = st.geom;
    assign mode_o       = st.mode;

    // Each check looks one cycle after the event that it guards, and all of
    // them sleep while reset is low.
    chk_base_high_read: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (data_rd_i && index_i == `IDX_BASE_HIGH) |=> data_rdata_o[7:6] == 2'b00)
        else $error("base high top bits read nonzero");

    chk_base_high_store: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (data_wr_i && index_i == `IDX_BASE_HIGH)
        |=> st.regs.base_high[7:6] == 2'b00)
        else $error("base high kept its top bits");

    chk_hit_pulse: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (data_rd_i && index_i >= `IDX_CONTROL && index_i <= `IDX_Y_HIGH)
        |=> data_hit_o)
        else $error("mapped read gave no hit");

    chk_unmapped_read: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (data_rd_i && (index_i < `IDX_CONTROL || index_i > `IDX_Y_HIGH))
        |=> !data_hit_o && data_rdata_o == 8'h00)
        else $error("unmapped read answered");

    // Read data holds until the next read so a slow host can still take it,
    // while the hit flag lasts a single cycle.
    chk_hit_idle: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        !data_rd_i |=> !data_hit_o && $stable(data_rdata_o))
        else $error("read answer moved without a read");

    chk_unmapped_write: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (data_wr_i && (index_i < `IDX_CONTROL || index_i > `IDX_Y_HIGH))
        |=> $stable(st.regs))
        else $error("unmapped write changed a register");

    // A read in the same cycle as a write to that register sees the old value.
    chk_read_before_write: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (data_rd_i && data_wr_i && index_i == `IDX_X_LOW)
        |=> data_rdata_o == $past(st.regs.x_low))
        else $error("same-cycle read saw the new value");

    // A write to the low X byte and a read of it in the very next cycle.
    sequence seq_x_low_write;
        data_wr_i && index_i == `IDX_X_LOW;
    endsequence

    sequence seq_x_low_read;
        data_rd_i && !data_wr_i && index_i == `IDX_X_LOW;
    endsequence

    chk_readback_value: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        seq_x_low_write ##1 seq_x_low_read
        |=> data_rdata_o == $past(data_wdata_i, 2))
        else $error("x low does not read back");

    chk_height_lines: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.height_lines ==
            ({3'b000, $past(st.regs.height_ext)} + 11'h001) * 11'h004)
        else $error("height not field plus one times four");

    chk_vext_flag: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.height_override ==
            $past(st.regs.control[3]))
        else $error("vertical extension flag wrong");

    chk_origin_flag: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.origin_active ==
            $past(st.regs.control[4]))
        else $error("origin select wrong");

    chk_base_bits: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.base_offset ==
            {$past(st.regs.base_high[5:0]), $past(st.regs.base_low[7:4]),
             12'h000})
        else $error("base offset assembled wrong");

    chk_base_high_bits: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.base_offset[21:16] ==
            $past(st.regs.base_high[5:0]))
        else $error("base offset top bits wrong");

    chk_addr_in_space: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.pattern_addr[21:12] ==
            geometry_o.base_offset[21:12])
        else $error("pattern outside 4KB space");

    chk_pattern_index: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> geometry_o.pattern_index ==
            $past(st.regs.base_low[3:0]))
        else $error("pattern index wrong");

    chk_x_position: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> {geometry_o.x_sign, geometry_o.x_mag} ==
            {$past(st.regs.x_high[7]), $past(st.regs.x_high[2:0]),
             $past(st.regs.x_low)})
        else $error("x position wrong");

    chk_y_position: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> {geometry_o.y_sign, geometry_o.y_mag} ==
            {$past(st.regs.y_high[7]), $past(st.regs.y_high[2:0]),
             $past(st.regs.y_low)})
        else $error("y position wrong");

    chk_hold_between: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        !frame_start_i |=> $stable(geometry_o))
        else $error("geometry changed outside frame start");

    chk_pattern_addr: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (frame_start_i && st.regs.control[2:0] == 3'h1)
        |=> geometry_o.pattern_addr[11:0] ==
            {geometry_o.pattern_index, 8'h00})
        else $error("pattern address wrong for 32x32 mode");

    // When the magnitude fields already match what is shown, a new frame must
    // leave the magnitude alone whatever the reserved bits now hold.
    chk_reserved_pos: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (frame_start_i && st.regs.x_low == geometry_o.x_mag[7:0]
         && st.regs.x_high[2:0] == geometry_o.x_mag[10:8])
        |=> $stable(geometry_o.x_mag))
        else $error("reserved bits moved the cursor");

    chk_reserved_y_pos: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (frame_start_i && st.regs.y_low == geometry_o.y_mag[7:0]
         && st.regs.y_high[2:0] == geometry_o.y_mag[10:8])
        |=> $stable(geometry_o.y_mag))
        else $error("reserved bits moved the cursor vertically");

    chk_mode_latch: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        frame_start_i |=> mode_o == $past(st.regs.control[2:0]))
        else $error("cursor mode not taken at frame start");

    chk_addr_large: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (frame_start_i && st.regs.control[2:1] == 2'b01)
        |=> geometry_o.pattern_addr[11:0] ==
            {geometry_o.pattern_index[0], 11'h000})
        else $error("pattern address wrong for 128x128 modes");

    chk_addr_medium: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (frame_start_i && st.regs.control[2] && !(&st.regs.control[1:0]))
        |=> geometry_o.pattern_addr[11:0] ==
            {geometry_o.pattern_index[1:0], 10'h000})
        else $error("pattern address wrong for 64x64 modes");
endmodule : cursor2_geom_regs
`default_nettype wire

// ===== src/cursor2_geom_regs.svh
`ifndef CURSOR2_GEOM_REGS_SVH
`define CURSOR2_GEOM_REGS_SVH
`define IDX_CONTROL      8'hA8
`define IDX_HEIGHT_EXT   8'hA9
`define IDX_BASE_LOW     8'hAA
`define IDX_BASE_HIGH    8'hAB
`define IDX_X_LOW        8'hAC
`define IDX_X_HIGH       8'hAD
`define IDX_Y_LOW        8'hAE
`define IDX_Y_HIGH       8'hAF
`define RST_BYTE         8'h00
`define CTL_VEXT_BIT     3
`define CTL_ORIGIN_BIT   4
`define BASE_LOW_ADDR_LSB 4
`define BASE_HIGH_MASK   8'h3F
`define POS_SIGN_BIT     7
`define POS_MAG_HI_MASK  8'h07
`define HEIGHT_LINE_SHIFT 2
`endif

// ===== src/cursor2_geom_pkg.sv
package cursor2_geom_pkg;
    typedef enum logic [2:0] {
        MODE_OFF, MODE_32_ANDXOR, MODE_128_2COL, MODE_128_1COL,
        MODE_64_3COL, MODE_64_ANDXOR, MODE_64_4COL, MODE_RSVD
    } cursor_mode_t;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] height_ext;
        logic [7:0] base_low;
        logic [7:0] base_high;
        logic [7:0] x_low;
        logic [7:0] x_high;
        logic [7:0] y_low;
        logic [7:0] y_high;
    } reg_file_t;

    typedef struct packed {
        logic        origin_active;
        logic [10:0] height_lines;
        logic        height_override;
        logic [21:0] base_offset;
        logic [3:0]  pattern_index;
        logic [21:0] pattern_addr;
        logic        x_sign;
        logic [10:0] x_mag;
        logic        y_sign;
        logic [10:0] y_mag;
    } geometry_t;
endpackage : cursor2_geom_pkg

// ===== src/cursor2_pattern_addr.sv
`timescale 1ns/1ps
`default_nettype none
// Pattern start address from base, index and the mode's pattern size.
module cursor2_pattern_addr
(
    input  wire logic [21:0]  base_i,
    input  wire logic [3:0]   index_i,
    input  wire logic [2:0]   mode_i,
    output logic      [21:0]  addr_o
);
    logic [11:0] size_bytes;
    logic [15:0] product;

    always_comb
    begin
        // Bytes per pattern: 32x32x2bpp=256, 128x128x1bpp=2048,
        // 64x64x2bpp=1024. Disabled and reserved modes count as zero.
        case (cursor2_geom_pkg::cursor_mode_t'(mode_i))
            cursor2_geom_pkg::MODE_32_ANDXOR: size_bytes = 12'h100;
            cursor2_geom_pkg::MODE_128_2COL,
            cursor2_geom_pkg::MODE_128_1COL:  size_bytes = 12'h800;
            cursor2_geom_pkg::MODE_64_3COL,
            cursor2_geom_pkg::MODE_64_ANDXOR,
            cursor2_geom_pkg::MODE_64_4COL:   size_bytes = 12'h400;
            default:                          size_bytes = 12'h000;
        endcase
        product = {4'h0, size_bytes} * {12'h000, index_i};
        // Indices beyond the 4KB space wrap inside it, never outside.
        addr_o = {base_i[21:12], product[11:0]};
    end
endmodule : cursor2_pattern_addr
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                        sys_clk_i     = 1'b0;
    logic                        rstn_i        = 1'b0;
    logic [7:0]                  index_i       = 8'h00;
    logic                        data_wr_i     = 1'b0;
    logic                        data_rd_i     = 1'b0;
    logic [7:0]                  data_wdata_i  = 8'h00;
    logic                        frame_start_i = 1'b0;
    logic [7:0]                  data_rdata_o;
    logic                        data_hit_o;
    cursor2_geom_pkg::geometry_t geo;
    logic [2:0]                  mode_o;
    int                          bad_count     = 0;
    int                          comparisons   = 0;

    cursor2_geom_regs uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .index_i(index_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
        .data_wdata_i(data_wdata_i), .frame_start_i(frame_start_i),
        .data_rdata_o(data_rdata_o), .data_hit_o(data_hit_o),
        .geometry_o(geo), .mode_o(mode_o));

    always #20 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Every driver task starts and ends 1 ns after a rising edge and lets
    // an idle edge pass, so no strobe is dropped and raised in one step.
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        index_i = idx;
        data_wdata_i = val;
        data_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        data_wr_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                      input logic hit);
        index_i = idx;
        data_rd_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        data_rd_i = 1'b0;
        chk({24'h0, data_rdata_o}, {24'h0, exp});
        chk({31'h0, data_hit_o}, {31'h0, hit});
        @(posedge sys_clk_i);
        #1;
    endtask : rd

    task automatic frame();
        frame_start_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        frame_start_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : frame

    task automatic t_reset();
        for (int k = 0; k < 8; k++)
            rd(8'hA8 + k[7:0], 8'h00, 1'b1);
        rd(8'hA7, 8'h00, 1'b0);
        rd(8'hB0, 8'h00, 1'b0);
        chk({31'h0, geo.height_override}, 32'h0);
        chk({31'h0, geo.origin_active}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        logic [7:0] v;
        for (int k = 0; k < 8; k++)
            wr(8'hA8 + k[7:0], 8'hC3 ^ (k[7:0] * 8'h11));
        wr(8'hA7, 8'hFF);
        for (int k = 0; k < 8; k++)
        begin
            v = 8'hC3 ^ (k[7:0] * 8'h11);
            rd(8'hA8 + k[7:0], (k == 3) ? (v & 8'h3F) : v, 1'b1);
        end
        rd(8'hA7, 8'h00, 1'b0);
        $display("test register readback done");
    endtask : t_regs

    task automatic t_geom();
        wr(8'hA8, 8'h19);
        wr(8'hA9, 8'h7E);
        wr(8'hAA, 8'h95);
        wr(8'hAB, 8'hEA);
        wr(8'hAC, 8'h34);
        wr(8'hAD, 8'hFD);
        wr(8'hAE, 8'hC3);
        wr(8'hAF, 8'h7A);
        // Nothing may reach the cursor before the frame boundary.
        chk({10'h0, geo.base_offset}, 32'h0);
        frame();
        chk({31'h0, geo.origin_active}, 32'h1);
        chk({31'h0, geo.height_override}, 32'h1);
        chk({21'h0, geo.height_lines}, 32'h1FC);
        chk({10'h0, geo.base_offset}, 32'h2A9000);
        chk({28'h0, geo.pattern_index}, 32'h5);
        chk({10'h0, geo.pattern_addr}, 32'h2A9500);
        chk({20'h0, geo.x_sign, geo.x_mag}, 32'hD34);
        chk({20'h0, geo.y_sign, geo.y_mag}, 32'h2C3);
        chk({29'h0, mode_o}, 32'h1);
        $display("test geometry done");
    endtask : t_geom

    task automatic t_modes();
        int sz[8] = '{0, 256, 2048, 2048, 1024, 1024, 1024, 0};
        logic [11:0] off;
        wr(8'hAD, 8'h85);
        for (int m = 0; m < 8; m++)
        begin
            wr(8'hA8, {5'h00, m[2:0]});
            frame();
            off = 12'(5 * sz[m]);
            chk({29'h0, mode_o}, {29'h0, m[2:0]});
            chk({31'h0, geo.height_override}, 32'h0);
            chk({31'h0, geo.origin_active}, 32'h0);
            chk({10'h0, geo.pattern_addr}, {10'h2A9, off});
            chk({20'h0, geo.x_sign, geo.x_mag}, 32'hD34);
        end
        $display("test modes done");
    endtask : t_modes

    // A read right behind a write, then a read in the same cycle as a write.
    task automatic t_back();
        index_i = 8'hAC;
        data_wdata_i = 8'h5A;
        data_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        data_wr_i = 1'b0;
        data_rd_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk({24'h0, data_rdata_o}, 32'h5A);
        data_wdata_i = 8'hA5;
        data_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        data_wr_i = 1'b0;
        data_rd_i = 1'b0;
        chk({24'h0, data_rdata_o}, 32'h5A);
        chk({31'h0, data_hit_o}, 32'h1);
        @(posedge sys_clk_i);
        #1;
        rd(8'hAC, 8'hA5, 1'b1);
        wr(8'hA9, 8'hFF);
        frame();
        chk({21'h0, geo.height_lines}, 32'h400);
        chk({20'h0, geo.x_sign, geo.x_mag}, 32'hDA5);
        $display("test back to back done");
    endtask : t_back

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    initial
    begin
        #(40 * 5000);
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        #1;
        rstn_i = 1'b1;
        t_reset();
        t_regs();
        t_geom();
        t_modes();
        t_back();
        conclude();
    end
endmodule : testbench
`default_nettype wire
